// ### rtl/fast_gate_defs.svh
// offsets, field positions, reset values and timing counts of the fast a20/reset block
`ifndef FAST_GATE_DEFS_SVH
`define FAST_GATE_DEFS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_MHZ 20
`define ALT_RST_DELAY_NS 14000
`define ALT_RST_PULSE_NS 6000
// least times round up to whole cycles
`define NS_TO_CYCLES_UP(ns) ((((ns) * `CLK_FREQ_MHZ) + 999) / 1000)
`define ALT_RST_DELAY_CYCLES `NS_TO_CYCLES_UP(`ALT_RST_DELAY_NS)
`define ALT_RST_PULSE_CYCLES `NS_TO_CYCLES_UP(`ALT_RST_PULSE_NS)
`define STRONG_DRIVE_CLOCKS 4

// ----------------------------------------------------------------------------
// register map (byte addresses on the axi4-lite bus)
// ----------------------------------------------------------------------------
`define FAST_PORT_INDEX 12'h092
`define FAST_PORT_ADDR ((`FAST_PORT_INDEX) << 2)
`define CFG_ADDR 12'h000
`define STATUS_ADDR 12'h004

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define FAST_RST_BIT 0
`define FAST_A20_BIT 1
`define FAST_FIXED_MASK 8'hfc
`define FAST_FIXED_VALUE 8'h24
`define FAST_RESET 8'h24
`define CFG_KRST_POL_BIT 0
`define CFG_FAST_EN_BIT 2
`define CFG_OD12_BIT 4
`define CFG_OD16_BIT 5
`define CFG_GP_DIR_BIT 6
`define CFG_GP_INV_BIT 7
`define CFG_RESET 8'h00
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ### rtl/fast_gate_pkg.sv
// types shared by the fast a20/reset block
package fast_gate_pkg;

   typedef enum logic [3:0] {
      RST_IDLE  = 4'h1,
      RST_DELAY = 4'h2,
      RST_PULSE = 4'h4,
      RST_DONE  = 4'h8
   } alt_rst_state_t;

   typedef enum logic [1:0] {
      SEL_CFG    = 2'h0,
      SEL_FAST   = 2'h1,
      SEL_STATUS = 2'h2,
      SEL_NONE   = 2'h3
   } reg_sel_t;

endpackage

// ### rtl/port_pin_if.sv
// carrier between the top and one keyboard-controller port output driver
`timescale 1ns/1ps
interface port_pin_if;
   logic level;
   logic open_drain;
   logic pin_out;
   logic pin_oe;
   logic pullup_en;
   modport drv (
      input level,
      input open_drain,
      output pin_out,
      output pin_oe,
      output pullup_en
   );
   modport ctl (
      output level,
      output open_drain,
      input pin_out,
      input pin_oe,
      input pullup_en
   );
endinterface

// ### rtl/kbc_port_driver.sv
// push-pull / open-drain driver for one keyboard-controller port output pin
`timescale 1ns/1ps
`include "fast_gate_defs.svh"
module kbc_port_driver #(
   parameter int STRONG_CLOCKS = `STRONG_DRIVE_CLOCKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   port_pin_if.drv pin
);

   logic level_d;
   logic [7:0] strong_cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_d <= 1'b1;
         strong_cnt <= 8'h00;
         pin.pin_out <= 1'b1;
         pin.pin_oe <= 1'b0;
         pin.pullup_en <= 1'b1;
      end else begin
         level_d <= pin.level;
         if (pin.open_drain) begin
            // no strong drive: a one releases the wire for wired-and sharing
            strong_cnt <= 8'h00;
            pin.pin_out <= 1'b0;
            pin.pin_oe <= !pin.level;
            pin.pullup_en <= 1'b0;
         end else begin
            pin.pullup_en <= 1'b1;
            if (!pin.level) begin
               strong_cnt <= 8'h00;
               pin.pin_out <= 1'b0;
               pin.pin_oe <= 1'b1;
            end else if (!level_d) begin
               // rising edge: strong high for STRONG_CLOCKS cycles in all
               strong_cnt <= 8'(STRONG_CLOCKS - 1);
               pin.pin_out <= 1'b1;
               pin.pin_oe <= 1'b1;
            end else if (strong_cnt != 8'h00) begin
               strong_cnt <= strong_cnt - 8'h01;
            end else begin
               // weak pull-up holds the level from here on
               pin.pin_out <= 1'b1;
               pin.pin_oe <= 1'b0;
            end
         end
      end
   end

endmodule

// ### rtl/fast_gate_a20_and_alt_reset.sv
// fast a20 gate and alternate cpu reset behind an axi4-lite register slave
//
// Contract
// - fast register dead unless config bit 2 set
// - reserved fast bits read fixed 001001 pattern
// - alternate a20 follows last written bit 1
// - system reset clears alternate reset bit 0
// - wait 14us, then reset low 6us
// - no new pulse until bit 0 cleared
// - alternate reset idles high after reset
// - and both resets onto keyboard reset (alternate reset only while bit 2 set), polarity
// - a20 mask high if any source high (alternate a20, port bit 21, cpu reset)
// - alternate a20 low after reset
// - push-pull: low, brief strong high, pull-up
// - open-drain: low or released, no strong drive
// - port pins ignore gp input/invert settings
// - a20 gate comes from port bit 21
`timescale 1ns/1ps
`include "fast_gate_defs.svh"
module fast_gate_a20_and_alt_reset #(
   parameter int DELAY_CYCLES = `ALT_RST_DELAY_CYCLES,
   parameter int PULSE_CYCLES = `ALT_RST_PULSE_CYCLES,
   parameter int STRONG_CLOCKS = `STRONG_DRIVE_CLOCKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic kbc_reset_n,
   input wire logic kbc_port_bit21,
   input wire logic kbc_port_bit12,
   input wire logic kbc_port_bit16,
   input wire logic cpu_reset_in,
   output logic alternate_a20_line,
   output logic alternate_reset_n,
   output logic cpu_a20_mask_n,
   output logic keyboard_reset_out,
   output logic port12_out,
   output logic port12_oe,
   output logic port12_pullup_en,
   output logic port16_out,
   output logic port16_oe,
   output logic port16_pullup_en
);

   localparam int CNT_W = 12;

   // --------------------------------------------------------------------------
   // address decode
   // --------------------------------------------------------------------------
   function automatic fast_gate_pkg::reg_sel_t decode(input logic [11:0] a);
      case ({a[11:2], 2'b00})
         `CFG_ADDR: decode = fast_gate_pkg::SEL_CFG;
         12'(`FAST_PORT_ADDR): decode = fast_gate_pkg::SEL_FAST;
         `STATUS_ADDR: decode = fast_gate_pkg::SEL_STATUS;
         default: decode = fast_gate_pkg::SEL_NONE;
      endcase
   endfunction

   // --------------------------------------------------------------------------
   // input synchronisers
   // --------------------------------------------------------------------------
   // order: cpu reset, port 16, port 12, port 21, kbc reset
   logic [4:0] sync_a, sync_b;
   logic kbc_reset_sync, kbc_gate_sync, port12_sync, port16_sync, cpu_reset_sync;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a <= 5'h01;
         sync_b <= 5'h01;
      end else begin
         sync_a <= {cpu_reset_in, kbc_port_bit16, kbc_port_bit12, kbc_port_bit21, kbc_reset_n};
         sync_b <= sync_a;
      end
   end

   assign {cpu_reset_sync, port16_sync, port12_sync, kbc_gate_sync, kbc_reset_sync}
      = sync_b;

   // --------------------------------------------------------------------------
   // axi4-lite write channel
   // --------------------------------------------------------------------------
   logic aw_held, w_held, w_lane0_q, wr_go;
   logic [11:0] aw_addr_q;
   logic [7:0] w_data_q;
   fast_gate_pkg::reg_sel_t wr_sel;

   assign wr_go = aw_held && w_held && !bvalid;
   assign wr_sel = decode(aw_addr_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 8'h00;
         w_lane0_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
            awready <= 1'b0;
         end else if (!aw_held && !awready && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata[7:0];
            w_lane0_q <= wstrb[0];
            wready <= 1'b0;
         end else if (!w_held && !wready && !bvalid) begin
            wready <= 1'b1;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `AXI_RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp <= (wr_sel == fast_gate_pkg::SEL_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------------------
   // registers
   // --------------------------------------------------------------------------
   // the gp direction/invert bits are kept for software but never reach the
   // port pins while they serve the keyboard-controller function
   logic [7:0] cfg;
   logic fast_a20, fast_rst, fast_en;

   assign fast_en = cfg[`CFG_FAST_EN_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= `CFG_RESET;
      end else if (wr_go && w_lane0_q && wr_sel == fast_gate_pkg::SEL_CFG) begin
         cfg <= w_data_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fast_a20 <= 1'(`FAST_RESET >> `FAST_A20_BIT);
         fast_rst <= 1'b0;
      end else if (wr_go && w_lane0_q && wr_sel == fast_gate_pkg::SEL_FAST && fast_en) begin
         fast_a20 <= w_data_q[`FAST_A20_BIT];
         fast_rst <= w_data_q[`FAST_RST_BIT];
      end
   end

   // --------------------------------------------------------------------------
   // axi4-lite read channel
   // --------------------------------------------------------------------------
   fast_gate_pkg::alt_rst_state_t rst_state;
   fast_gate_pkg::reg_sel_t rd_sel;
   logic [7:0] rd_byte;
   logic [1:0] rd_resp;

   assign rd_sel = decode(araddr);

   always_comb begin
      rd_byte = 8'h00;
      rd_resp = `AXI_RESP_OKAY;
      case (rd_sel)
         fast_gate_pkg::SEL_CFG: rd_byte = cfg;
         fast_gate_pkg::SEL_FAST: begin
            if (fast_en) begin
               rd_byte = (`FAST_FIXED_VALUE & `FAST_FIXED_MASK)
                  | (8'(fast_a20) << `FAST_A20_BIT) | (8'(fast_rst) << `FAST_RST_BIT);
            end
         end
         fast_gate_pkg::SEL_STATUS: begin
            rd_byte = {2'b00, kbc_gate_sync, rst_state != fast_gate_pkg::RST_IDLE,
               keyboard_reset_out, cpu_a20_mask_n, alternate_a20_line, alternate_reset_n};
         end
         default: rd_resp = `AXI_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `AXI_RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_resp;
         end else begin
            if (rvalid && rready) begin
               rvalid <= 1'b0;
            end
            if (!arready && !rvalid) begin
               arready <= 1'b1;
            end
         end
      end
   end

   // --------------------------------------------------------------------------
   // alternate reset pulse generator
   // --------------------------------------------------------------------------
   // clearing bit 0 during the delay abandons the request; a pulse once
   // started always runs its full width so the cpu sees a clean reset
   logic [CNT_W-1:0] rst_cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_state <= fast_gate_pkg::RST_IDLE;
         rst_cnt <= '0;
         alternate_reset_n <= 1'b1;
      end else begin
         case (rst_state)
            fast_gate_pkg::RST_IDLE: begin
               if (fast_rst) begin
                  rst_state <= fast_gate_pkg::RST_DELAY;
                  rst_cnt <= CNT_W'(DELAY_CYCLES - 1);
               end
            end
            fast_gate_pkg::RST_DELAY: begin
               if (!fast_rst) begin
                  rst_state <= fast_gate_pkg::RST_IDLE;
               end else if (rst_cnt == '0) begin
                  rst_state <= fast_gate_pkg::RST_PULSE;
                  rst_cnt <= CNT_W'(PULSE_CYCLES - 1);
                  alternate_reset_n <= 1'b0;
               end else begin
                  rst_cnt <= rst_cnt - 1'b1;
               end
            end
            fast_gate_pkg::RST_PULSE: begin
               if (rst_cnt == '0) begin
                  rst_state <= fast_gate_pkg::RST_DONE;
                  alternate_reset_n <= 1'b1;
               end else begin
                  rst_cnt <= rst_cnt - 1'b1;
               end
            end
            fast_gate_pkg::RST_DONE: begin
               if (!fast_rst) begin
                  rst_state <= fast_gate_pkg::RST_IDLE;
               end
            end
            default: begin
               rst_state <= fast_gate_pkg::RST_IDLE;
               alternate_reset_n <= 1'b1;
            end
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // a20 and keyboard reset outputs
   // --------------------------------------------------------------------------
   // the mask lags bit 1 by two clocks since the line itself is a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alternate_a20_line <= 1'b0;
         cpu_a20_mask_n <= 1'b0;
         keyboard_reset_out <= 1'b1;
      end else begin
         alternate_a20_line <= fast_a20;
         cpu_a20_mask_n <= alternate_a20_line | kbc_gate_sync | cpu_reset_sync;
         keyboard_reset_out <= (kbc_reset_sync & (alternate_reset_n | !fast_en))
            ^ cfg[`CFG_KRST_POL_BIT];
      end
   end

   // --------------------------------------------------------------------------
   // keyboard-controller port output pins
   // --------------------------------------------------------------------------
   // levels come straight from the port bits; gp direction and inversion
   // are deliberately not applied here
   port_pin_if p12_if (), p16_if ();

   assign p12_if.level = port12_sync;
   assign p12_if.open_drain = cfg[`CFG_OD12_BIT];
   assign p16_if.level = port16_sync;
   assign p16_if.open_drain = cfg[`CFG_OD16_BIT];

   kbc_port_driver #(.STRONG_CLOCKS(STRONG_CLOCKS)) u_port12 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(p12_if.drv)
   );

   kbc_port_driver #(.STRONG_CLOCKS(STRONG_CLOCKS)) u_port16 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(p16_if.drv)
   );

   assign port12_out = p12_if.pin_out;
   assign port12_oe = p12_if.pin_oe;
   assign port12_pullup_en = p12_if.pullup_en;
   assign port16_out = p16_if.pin_out;
   assign port16_oe = p16_if.pin_oe;
   assign port16_pullup_en = p16_if.pullup_en;

endmodule

// ### testbench/kbc_model.sv
// keyboard-controller side model driving its port, gate and reset lines
`timescale 1ns/1ps
module kbc_model (
   input logic aclk,
   input logic slow,
   input logic [4:0] cmd,
   output logic kbc_reset_n,
   output logic kbc_port_bit21,
   output logic kbc_port_bit12,
   output logic kbc_port_bit16,
   output logic cpu_reset_in
);
   logic [4:0] lag = 5'h10;
   logic [4:0] q = 5'h10;
   // lines move only after an edge; slow mode answers one clock late
   always @(posedge aclk) begin
      lag <= cmd;
      q <= slow ? lag : cmd;
   end
   // gate is an ordinary firmware-driven port output
   assign {kbc_reset_n, kbc_port_bit21, kbc_port_bit12, kbc_port_bit16, cpu_reset_in} = q;
endmodule

// ### testbench/fast_gate_chk.sv
// concurrent checks on the ports of the fast a20 / alternate reset block
`timescale 1ns/1ps
`include "fast_gate_defs.svh"
module fast_gate_chk #(
   parameter int DELAY_CYCLES = 280,
   parameter int PULSE_CYCLES = 120,
   parameter int STRONG_CLOCKS = 4
) (
   input logic aclk,
   input logic aresetn,
   input logic [11:0] awaddr,
   input logic [31:0] wdata,
   input logic wvalid,
   input logic wready,
   input logic bvalid,
   input logic kbc_port_bit21,
   input logic cpu_reset_in,
   input logic alternate_a20_line,
   input logic alternate_reset_n,
   input logic cpu_a20_mask_n,
   input logic port12_out,
   input logic port12_oe,
   input logic port12_pullup_en
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [9:0] lo_cnt, since_set, strong_cnt;
   logic prev_n, spent;
   wire fast_wr = wvalid && wready && awaddr == `FAST_PORT_ADDR;
   always_ff @(posedge aclk) begin
      if (!aresetn) lo_cnt <= '0;
      else lo_cnt <= alternate_reset_n ? '0 : lo_cnt + 10'h001;
   end
   // saturates so a long idle span cannot wrap into a false short delay
   always_ff @(posedge aclk) begin
      if (!aresetn || (fast_wr && wdata[0])) since_set <= '0;
      else if (since_set != 10'h3ff) since_set <= since_set + 10'h001;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_n <= 1'b1;
         spent <= 1'b0;
      end else begin
         prev_n <= alternate_reset_n;
         if (fast_wr && !wdata[0]) spent <= 1'b0;
         else if (alternate_reset_n && !prev_n) spent <= 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || !(port12_oe && port12_out)) strong_cnt <= '0;
      else strong_cnt <= strong_cnt + 10'h001;
   end
   chk_mask_high: assert property (alternate_a20_line[*2] |-> cpu_a20_mask_n)
      else $error("a20 mask low while alternate a20 high");
   chk_mask_low: assert property ((!alternate_a20_line && !kbc_port_bit21
      && !cpu_reset_in)[*5] |-> !cpu_a20_mask_n)
      else $error("a20 mask high with all sources low");
   chk_rst_width: assert property ($rose(alternate_reset_n) && $past(aresetn)
      |-> lo_cnt == PULSE_CYCLES)
      else $error("alternate reset pulse width wrong");
   chk_rst_delay: assert property ($fell(alternate_reset_n) |-> since_set >= DELAY_CYCLES)
      else $error("alternate reset pulse came too soon");
   chk_rst_once: assert property ($fell(alternate_reset_n) |-> !spent)
      else $error("second pulse without clearing the request");
   chk_reset_idle: assert property ($rose(aresetn)
      |-> alternate_reset_n && !alternate_a20_line && !bvalid)
      else $error("outputs not idle after reset");
   chk_od_weak: assert property (!port12_pullup_en |-> !(port12_oe && port12_out))
      else $error("strong drive in open-drain mode");
   chk_strong_len: assert property (port12_oe && port12_out |-> strong_cnt < STRONG_CLOCKS)
      else $error("strong high drive too long");
   chk_strong_end: assert property ($fell(port12_oe) && port12_pullup_en && $past(aresetn)
      |-> strong_cnt == STRONG_CLOCKS)
      else $error("strong high drive too short");
endmodule
bind fast_gate_a20_and_alt_reset fast_gate_chk #(
   .DELAY_CYCLES(DELAY_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES),
   .STRONG_CLOCKS(STRONG_CLOCKS)
) u_fast_gate_chk (.aclk, .aresetn, .awaddr, .wdata, .wvalid, .wready, .bvalid,
   .kbc_port_bit21, .cpu_reset_in, .alternate_a20_line, .alternate_reset_n,
   .cpu_a20_mask_n, .port12_out, .port12_oe, .port12_pullup_en);

// ### testbench/fast_gate_a20_and_alt_reset_bench.sv
// self-checking bench for the fast a20 gate and alternate reset block
`timescale 1ns/1ps
`include "fast_gate_defs.svh"
module fast_gate_a20_and_alt_reset_bench;
   // short timers keep the run brief
   localparam int DP = 3;
   localparam int PP = 2;
   localparam int SP = 2;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic slow = 1'b0;
   logic [4:0] cmd = 5'h10;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic k_rst_n, k21, k12, k16, k_cpu, a20, arst_n, mask_n, kb_out;
   logic [5:0] pins;
   logic [31:0] exp_q[$];
   logic [7:0] seed = 8'h05;
   int num_errors = 0;
   int checked = 0;
   int m;
   fast_gate_a20_and_alt_reset #(.DELAY_CYCLES(DP), .PULSE_CYCLES(PP), .STRONG_CLOCKS(SP))
   u_fast_gate_a20_and_alt_reset (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .kbc_reset_n(k_rst_n),
      .kbc_port_bit21(k21), .kbc_port_bit12(k12), .kbc_port_bit16(k16),
      .cpu_reset_in(k_cpu), .alternate_a20_line(a20), .alternate_reset_n(arst_n),
      .cpu_a20_mask_n(mask_n), .keyboard_reset_out(kb_out), .port12_out(pins[5]),
      .port12_oe(pins[4]), .port12_pullup_en(pins[3]), .port16_out(pins[2]),
      .port16_oe(pins[1]), .port16_pullup_en(pins[0]));
   kbc_model u_kbc_model (.aclk(aclk), .slow(slow), .cmd(cmd), .kbc_reset_n(k_rst_n),
      .kbc_port_bit21(k21), .kbc_port_bit12(k12), .kbc_port_bit16(k16),
      .cpu_reset_in(k_cpu));
   always #25 aclk = ~aclk;
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask
   // --------
   // bus master: one transfer at a time, expectations queued first
   // --------
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      logic pend;
      pend = 1'b1;
      exp_q.push_back({r, 30'h0});
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pend) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            pend = 1'b0;
         end
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] r, input logic [7:0] d);
      logic pend;
      pend = 1'b1;
      exp_q.push_back({r, 22'h0, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (pend) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            pend = 1'b0;
         end
      end
   endtask
   always @(posedge aclk) begin
      if (bvalid && bready) check({bresp, 30'h0}, exp_q.pop_front());
      if (rvalid && rready) check({rresp, rdata[29:0]}, exp_q.pop_front());
   end
   task automatic pulse(input logic e);
      int hi, lo, kb;
      hi = 0;
      lo = 0;
      kb = 0;
      repeat (DP + PP + 12) begin
         @(posedge aclk);
         if (arst_n !== 1'b1) lo++;
         else if (lo == 0) hi++;
         if (kb_out !== 1'b1) kb = 1;
      end
      check(lo, e ? PP : 0);
      if (e) check(hi >= DP, 1);
      check(kb, e);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      tick(20000);
      num_errors++;
      results();
   end
   initial begin
      tick(20);
      aresetn <= 1'b1;
      tick(2);
      check({arst_n, a20, mask_n, kb_out}, 4'b1001);
      rd(`CFG_ADDR, `AXI_RESP_OKAY, 8'h00);
      wr(`FAST_PORT_ADDR, 8'h03, `AXI_RESP_OKAY);
      rd(`FAST_PORT_ADDR, `AXI_RESP_OKAY, 8'h00);
      pulse(1'b0);
      check(a20, 1'b0);
      rd(12'h100, `AXI_RESP_SLVERR, 8'h00);
      wr(12'h100, 8'hff, `AXI_RESP_SLVERR);
      $display("test reset and disabled register done");
      seed = lfsr(seed);
      wr(`CFG_ADDR, {seed[7:6], 6'h04}, `AXI_RESP_OKAY);
      rd(`FAST_PORT_ADDR, `AXI_RESP_OKAY, 8'h24);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         cmd <= {1'b1, i[1], 3'b000};
         slow <= i[0];
         wr(`FAST_PORT_ADDR, {seed[7:2], i[0], 1'b0}, `AXI_RESP_OKAY);
         rd(`FAST_PORT_ADDR, `AXI_RESP_OKAY, {6'h09, i[0], 1'b0});
         tick(5);
         check({a20, mask_n}, {i[0], i[0] | i[1]});
      end
      wr(`FAST_PORT_ADDR, 8'h00, `AXI_RESP_OKAY);
      cmd <= 5'h11;
      tick(6);
      check(mask_n, 1'b1);
      cmd <= 5'h10;
      tick(6);
      check(mask_n, 1'b0);
      $display("test a20 gating done");
      wr(`FAST_PORT_ADDR, 8'h01, `AXI_RESP_OKAY);
      pulse(1'b1);
      rd(`FAST_PORT_ADDR, `AXI_RESP_OKAY, 8'h25);
      wr(`FAST_PORT_ADDR, 8'h01, `AXI_RESP_OKAY);
      pulse(1'b0);
      wr(`FAST_PORT_ADDR, 8'h00, `AXI_RESP_OKAY);
      wr(`FAST_PORT_ADDR, 8'h01, `AXI_RESP_OKAY);
      pulse(1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(`CFG_ADDR, {7'h02, i[0]}, `AXI_RESP_OKAY);
         cmd <= {i[1], 4'h0};
         tick(6);
         check(kb_out, i[1] ^ i[0]);
      end
      $display("test alternate reset done");
      // mid-run reset with the request bit still set
      cmd <= 5'h10;
      aresetn <= 1'b0;
      tick(3);
      aresetn <= 1'b1;
      tick(2);
      rd(`CFG_ADDR, `AXI_RESP_OKAY, 8'h00);
      wr(`CFG_ADDR, 8'h04, `AXI_RESP_OKAY);
      rd(`FAST_PORT_ADDR, `AXI_RESP_OKAY, 8'h24);
      rd(`STATUS_ADDR, `AXI_RESP_OKAY, 8'h09);
      $display("test second reset done");
      for (int od = 0; od < 2; od++) begin
         wr(`CFG_ADDR, {2'b11, od[0], od[0], 4'h4}, `AXI_RESP_OKAY);
         cmd <= 5'h10;
         tick(6);
         check({pins[5:4], pins[2:1]}, 4'b0101);
         cmd <= 5'h16;
         m = 0;
         repeat (12) begin
            @(posedge aclk);
            if (pins[5:4] === 2'b11) m++;
         end
         check(m, od ? 0 : SP);
         check({pins[4:3], pins[1:0]}, od ? 4'b0000 : 4'b0101);
      end
      $display("test port drivers done");
      results();
   end
endmodule
